// file: ucg_pkg.sv
// Constants and types shared by the serial clock generation block
package ucg_pkg;
  // Register byte addresses on the APB bus
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BAUD_LO = 8'h04;
  localparam logic [7:0] ADDR_BAUD_HI = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h18;
  // Control register bit positions
  localparam int BIT_SYNC = 0;
  localparam int BIT_DS = 1;
  localparam int BIT_XDIR = 2;
  localparam int BIT_POL = 3;
  localparam int BIT_PAR_EN = 4;
  localparam int BIT_PAR_ODD = 5;
  localparam int BIT_STOP2 = 6;
  localparam int BIT_PWR = 7;
  // Power reduction set at reset: software must clear it first
  localparam logic [7:0] CTRL_RESET = 8'h80;
  // Divisor layout: low byte plus high nibble
  localparam int DIV_W = 12;
  localparam int LO_W = 8;
  localparam int HI_W = 4;
  // Prescaler limits (states minus one) per mode
  localparam logic [3:0] LIM_NORM = 4'hf;
  localparam logic [3:0] LIM_DS = 4'h7;
  localparam logic [3:0] LIM_SYNC = 4'h1;
  // Interrupt flag positions
  localparam int IRQ_RXC = 0;
  localparam int IRQ_TXE = 1;
  localparam int IRQ_TXC = 2;
  localparam int IRQ_W = 3;
  // Frame: start, 8 data, parity or stop, stops
  localparam int DATA_W = 8;
  localparam int FRAME_W = 12;
  localparam logic [3:0] FRAME_BASE = 4'ha;
  localparam logic [2:0] DATA_LAST = 3'h7;
  // Receiver sequence
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } ucg_rx_t;
endpackage : ucg_pkg

// file: ucg_baud_if.sv
// Link between the top and the baud rate down-counter
`timescale 1ns/100ps
interface ucg_baud_if #(parameter int DIV_W = 12);
  logic [DIV_W-1:0] divisor; // Value loaded at each reload
  logic reload; // Restart the counter now
  logic enable; // Counter runs while high
  logic tick; // One-cycle generator output
  modport gen (input divisor, input reload, input enable, output tick);
  modport user (output divisor, output reload, output enable, input tick);
endinterface : ucg_baud_if

// file: ucg_baud_gen.sv
// Programmable baud rate down-counter
`timescale 1ns/100ps
module ucg_baud_gen
  import ucg_pkg::*;
#(
  parameter int DIV_W = 12
) (
  input wire logic clock,
  input wire logic rst,
  ucg_baud_if.gen bus
);

  if (DIV_W < 1 || DIV_W > 16) begin : g_chk
    $error("ucg_baud_gen: DIV_W out of range");
  end

  typedef struct packed {
    logic [DIV_W-1:0] cnt; // Down-counter
    logic tick; // Registered output pulse
  } ucg_gen_t;

  ucg_gen_t st;
  ucg_gen_t next_st;

  // Count down; reload on zero or on a low-byte write
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!bus.enable || bus.reload) begin
      next_st.cnt = bus.divisor;
    end else if (st.cnt == '0) begin
      next_st.cnt = bus.divisor;
      next_st.tick = 1'b1; // Period is divisor plus one
    end else begin
      next_st.cnt = st.cnt - 1'b1; // High byte alone never restarts
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.tick = st.tick;

  chk_gen_reload: assert property (@(posedge clock) disable iff (rst)
    bus.enable && bus.reload |=> st.cnt == $past(bus.divisor))
    else $error("counter did not reload");
  chk_gen_period: assert property (@(posedge clock) disable iff (rst)
    bus.enable && !bus.reload && st.cnt == '0 |=> st.tick)
    else $error("no tick after zero");
  chk_gen_no_restart: assert property (@(posedge clock) disable iff (rst)
    bus.enable && !bus.reload && st.cnt != '0
    |=> st.cnt == $past(st.cnt) - 1'b1 && !st.tick)
    else $error("counter disturbed");
endmodule : ucg_baud_gen

// file: ucg_top.sv
// Serial transceiver clock generation with small frame datapath
// Summary of operation
// - Four modes: async, double speed, master, slave
// - Direction bit picks internal or external clock
// - Clock pin used only in synchronous modes
// - Down-counter reloads at zero or low write
// - One pulse per zero; rate clock over divisor+1
// - Transmit divides by 16, 8 or 2
// - Divisor is twelve bits, high and low
// - Double speed ignored in synchronous modes
// - Double speed halves receive samples to 8
// - Slave clock synchronised then edge detected
// - Sample on edge opposite data change
// - Polarity picks change and sample edges
// - One transmit buffer allows gapless frames
// - Two-entry receive buffer with error flags
// - One frame format shared by both directions
`timescale 1ns/100ps
module ucg_top
  import ucg_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic transfer_clock_pin_in,
  output logic transfer_clock_pin_out,
  output logic transfer_clock_pin_oe_n,
  input wire logic receive_data_pin,
  output logic transmit_data_pin
);

  typedef struct packed {
    logic [7:0] ctrl; // Mode, format and power bits
    logic [LO_W-1:0] div_lo; // Divisor low byte
    logic [HI_W-1:0] div_hi; // Divisor high nibble
    logic [IRQ_W-1:0] mask; // Interrupt mask
    logic [IRQ_W-1:0] flags; // Sticky interrupt flags
    logic xs1; // Clock pin, first stage
    logic xs2; // Clock pin, second stage
    logic xs3; // Previous xs2 for edge detection
    logic rs1; // Data pin, first stage
    logic rs2; // Data pin, second stage
    logic xck_o; // Master clock level
    logic [3:0] presc; // Transmit prescaler
    logic [DATA_W-1:0] tx_buf; // Transmit holding buffer
    logic tx_full; // Holding buffer occupied
    logic [FRAME_W-1:0] tx_sh; // Transmit shift register
    logic [3:0] tx_left; // Bits left in current frame
    ucg_rx_t rx_st; // Receiver state
    logic [3:0] rx_ctr; // Recovery sample counter
    logic [2:0] rx_n; // Data bit index
    logic [DATA_W-1:0] rx_sh; // Receive shift register
    logic rx_acc; // Running parity
    logic rx_pe; // Parity error of frame
    logic [1:0][DATA_W+1:0] fifo; // {frame err, parity err, data}
    logic [1:0] rx_cnt; // Entries in receive buffer
    logic ovr; // Overrun, sticky until status read
    logic [31:0] prdata; // Read data, loaded in setup phase
  } ucg_st_t;

  ucg_st_t st;
  ucg_st_t next_st;
  ucg_baud_if #(.DIV_W(DIV_W)) baud ();

  // Mode decode
  logic sync, ds, master, pol, run;
  logic [3:0] lim;
  logic tick, m_rise, m_fall, rise, fall, tx_step, rx_strobe;
  logic acc, wr, rd, mapped, push, pop;
  logic [DATA_W+1:0] push_v;
  logic [FRAME_W-1:0] frame;
  logic [3:0] frame_len;
  logic [1:0] cnt_after;

  assign sync = st.ctrl[BIT_SYNC];
  assign ds = st.ctrl[BIT_DS] & ~sync; // Ignored when synchronous
  assign master = st.ctrl[BIT_XDIR]; // Output means internal clock
  assign pol = st.ctrl[BIT_POL];
  assign run = ~st.ctrl[BIT_PWR]; // Held off until cleared
  assign tick = baud.tick;

  // States per bit: 2 sync, 8 double, 16 normal
  assign lim = sync ? LIM_SYNC : (ds ? LIM_DS : LIM_NORM);

  // Master edges come from the generator; slave edges from synced pin
  assign m_rise = tick & ~st.xck_o;
  assign m_fall = tick & st.xck_o;
  // Slave edges only trusted below a quarter of clock rate
  assign rise = sync & (master ? m_rise : (st.xs2 & ~st.xs3));
  assign fall = sync & (master ? m_fall : (~st.xs2 & st.xs3));

  // Change on one edge, sample on the other
  assign tx_step = run & (sync ? (pol ? fall : rise)
                               : (tick & (st.presc == lim)));
  assign rx_strobe = run & (sync ? (pol ? rise : fall)
                                 : (tick & (st.rx_ctr == (lim >> 1))));

  // APB decode
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  always_comb begin
    if (paddr == ADDR_CTRL) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_BAUD_LO || paddr == ADDR_BAUD_HI) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_DATA || paddr == ADDR_STATUS) begin
      mapped = 1'b1;
    end else if (paddr == ADDR_IRQ || paddr == ADDR_MASK) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // Generator hookup; new low byte goes straight into the reload
  assign baud.enable = run;
  assign baud.reload = wr & (paddr == ADDR_BAUD_LO);
  assign baud.divisor = baud.reload ? {st.div_hi, pwdata[LO_W-1:0]}
                                    : {st.div_hi, st.div_lo};

  // Frame layout from the shared format bits
  assign frame = {2'b11,
    st.ctrl[BIT_PAR_EN] ? (^st.tx_buf ^ st.ctrl[BIT_PAR_ODD]) : 1'b1,
    st.tx_buf, 1'b0};
  assign frame_len = FRAME_BASE + {3'h0, st.ctrl[BIT_PAR_EN]}
                   + {3'h0, st.ctrl[BIT_STOP2]};

  ucg_baud_gen #(.DIV_W(DIV_W)) u_gen (
    .clock(clock),
    .rst(rst),
    .bus(baud.gen)
  );

  // Next-state logic for the whole block
  always_comb begin
    next_st = st;
    push = 1'b0;
    push_v = {~st.rs2, st.rx_pe, st.rx_sh};
    pop = rd & (paddr == ADDR_DATA) & (st.rx_cnt != 2'h0);
    cnt_after = st.rx_cnt;
    // Read clears come first so that a same-cycle event below wins
    if (rd && paddr == ADDR_IRQ) begin
      next_st.flags = st.flags & ~st.prdata[IRQ_W-1:0];
    end
    if (rd && paddr == ADDR_STATUS && st.prdata[3]) begin
      next_st.ovr = 1'b0; // Only when the overrun bit was shown
    end
    // Synchronisers: logic reads only the second stage
    next_st.xs1 = transfer_clock_pin_in;
    next_st.xs2 = st.xs1;
    next_st.xs3 = st.xs2;
    next_st.rs1 = receive_data_pin;
    next_st.rs2 = st.rs1;
    // Master clock toggles per generator pulse: divide by 2
    if (run & sync & master & tick) begin
      next_st.xck_o = ~st.xck_o;
    end
    // Asynchronous transmit prescaler
    if (!run || sync) begin
      next_st.presc = 4'h0;
    end else if (tick) begin
      next_st.presc = (st.presc == lim) ? 4'h0 : st.presc + 4'h1;
    end
    // Transmitter: buffer refills shift register at frame end
    if (tx_step) begin
      if (st.tx_left > 4'h1) begin
        next_st.tx_sh = {1'b1, st.tx_sh[FRAME_W-1:1]};
        next_st.tx_left = st.tx_left - 4'h1;
      end else if (st.tx_full) begin
        next_st.tx_sh = frame;
        next_st.tx_left = frame_len;
        next_st.tx_full = 1'b0;
        next_st.flags[IRQ_TXE] = 1'b1;
      end else if (st.tx_left == 4'h1) begin
        next_st.tx_left = 4'h0;
        next_st.flags[IRQ_TXC] = 1'b1;
      end
    end
    // Recovery counter runs on undivided ticks while a frame is open
    if (!sync && run && tick && st.rx_st != RX_IDLE) begin
      next_st.rx_ctr = (st.rx_ctr == lim) ? 4'h0 : st.rx_ctr + 4'h1;
    end
    // Receiver sequence
    case (st.rx_st)
      RX_IDLE: begin
        next_st.rx_acc = 1'b0;
        next_st.rx_n = 3'h0;
        if (sync && rx_strobe && !st.rs2) begin
          next_st.rx_st = RX_DATA;
        end else if (!sync && run && tick && !st.rs2) begin
          next_st.rx_st = RX_START;
          next_st.rx_ctr = 4'h1;
        end
      end
      RX_START: begin
        // A high mid-bit sample is a false start
        if (rx_strobe) begin
          next_st.rx_st = st.rs2 ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_strobe) begin
          next_st.rx_sh = {st.rs2, st.rx_sh[DATA_W-1:1]};
          next_st.rx_acc = st.rx_acc ^ st.rs2;
          next_st.rx_n = st.rx_n + 3'h1;
          next_st.rx_pe = 1'b0;
          if (st.rx_n == DATA_LAST) begin
            next_st.rx_st = st.ctrl[BIT_PAR_EN] ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rx_strobe) begin
          next_st.rx_pe = st.rx_acc ^ st.ctrl[BIT_PAR_ODD] ^ st.rs2;
          next_st.rx_st = RX_STOP;
        end
      end
      RX_STOP: begin
        // Second stop bit is not checked
        if (rx_strobe) begin
          push = 1'b1; // Frame error when stop reads low
          next_st.rx_st = RX_IDLE;
        end
      end
      default: begin
        next_st.rx_st = RX_IDLE;
      end
    endcase
    if (!run) begin
      next_st.rx_st = RX_IDLE;
    end
    // Two-entry receive buffer; head is entry 0
    if (pop) begin
      next_st.fifo[0] = st.fifo[1];
      cnt_after = st.rx_cnt - 2'h1;
    end
    if (push) begin
      next_st.flags[IRQ_RXC] = 1'b1;
      if (cnt_after == 2'h2) begin
        next_st.ovr = 1'b1; // Frame dropped
      end else begin
        next_st.fifo[cnt_after[0]] = push_v;
        cnt_after = cnt_after + 2'h1;
      end
    end
    next_st.rx_cnt = cnt_after;
    // Register writes at the access edge
    if (wr) begin
      if (paddr == ADDR_CTRL) begin
        next_st.ctrl = pwdata[7:0];
      end else if (paddr == ADDR_BAUD_LO) begin
        next_st.div_lo = pwdata[LO_W-1:0];
      end else if (paddr == ADDR_BAUD_HI) begin
        next_st.div_hi = pwdata[HI_W-1:0]; // No reload here
      end else if (paddr == ADDR_DATA) begin
        // A write to a full buffer is dropped
        if (!st.tx_full) begin
          next_st.tx_buf = pwdata[DATA_W-1:0];
          next_st.tx_full = 1'b1;
        end
      end else if (paddr == ADDR_MASK) begin
        next_st.mask = pwdata[IRQ_W-1:0];
      end
    end
    // Read data prepared in the setup phase
    next_st.prdata = 32'h0;
    if (psel && !penable && !pwrite) begin
      if (paddr == ADDR_CTRL) begin
        next_st.prdata[7:0] = st.ctrl;
      end else if (paddr == ADDR_BAUD_LO) begin
        next_st.prdata[LO_W-1:0] = st.div_lo;
      end else if (paddr == ADDR_BAUD_HI) begin
        next_st.prdata[HI_W-1:0] = st.div_hi;
      end else if (paddr == ADDR_DATA) begin
        next_st.prdata[DATA_W+1:0] = st.fifo[0];
      end else if (paddr == ADDR_STATUS) begin
        next_st.prdata[7:0] = {st.rx_cnt, st.fifo[0][DATA_W+1:DATA_W],
          st.ovr, st.tx_full, st.tx_left != 4'h0, st.rx_st != RX_IDLE};
      end else if (paddr == ADDR_IRQ) begin
        next_st.prdata[IRQ_W-1:0] = st.flags;
      end else if (paddr == ADDR_MASK) begin
        next_st.prdata[IRQ_W-1:0] = st.mask;
      end
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
      st.xs1 <= 1'b1;
      st.xs2 <= 1'b1;
      st.xs3 <= 1'b1;
      st.rs1 <= 1'b1;
      st.rs2 <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign prdata = st.prdata;
  assign pready = 1'b1; // Zero wait states
  assign pslverr = acc & ~mapped;
  assign irq = |(st.flags & st.mask);
  assign transfer_clock_pin_out = st.xck_o;
  assign transfer_clock_pin_oe_n = ~(run & sync & master);
  assign transmit_data_pin = (st.tx_left != 4'h0) ? st.tx_sh[0] : 1'b1;

  sequence s_master_tick;
    run && sync && master && tick;
  endsequence
  sequence s_toggled;
    st.xck_o != $past(st.xck_o);
  endsequence

  chk_pin_drive: assert property (@(posedge clock) disable iff (rst)
    !transfer_clock_pin_oe_n |-> sync && master)
    else $error("clock pin driven outside master mode");
  chk_master_toggle: assert property (@(posedge clock) disable iff (rst)
    s_master_tick |=> s_toggled)
    else $error("master clock missed a toggle");
  chk_sync_states: assert property (@(posedge clock) disable iff (rst)
    sync |-> lim == LIM_SYNC && !ds)
    else $error("double speed leaked into sync mode");
  chk_ds_states: assert property (@(posedge clock) disable iff (rst)
    !sync && st.ctrl[BIT_DS] |-> lim == LIM_DS)
    else $error("double speed sample count wrong");
  chk_slave_edge: assert property (@(posedge clock) disable iff (rst)
    sync && !master && rise |-> $past(st.xs1) && !$past(st.xs1, 2))
    else $error("slave edge without synced pin edge");
  chk_tx_gapless: assert property (@(posedge clock) disable iff (rst)
    tx_step && st.tx_left == 4'h1 && st.tx_full
    |=> st.tx_left == $past(frame_len) && !transmit_data_pin)
    else $error("gap between buffered frames");
  chk_rx_overrun: assert property (@(posedge clock) disable iff (rst)
    push && st.rx_cnt == 2'h2 && !pop |=> st.ovr && st.rx_cnt == 2'h2)
    else $error("overrun not flagged");
  chk_power_hold: assert property (@(posedge clock) disable iff (rst)
    !run |=> st.tx_left == $past(st.tx_left) && st.presc == 4'h0)
    else $error("block moved while powered down");
endmodule : ucg_top

// file: ucg_remote.sv
// Behavioural remote transceiver on the serial data and clock pins
`timescale 1ns/100ps
module ucg_remote (
  input wire logic clock,
  input wire logic txd,
  output logic rxd,
  output logic xck
);
  // Data line idles high; clock stands still between frames
  initial begin
    rxd = 1'b1;
    xck = 1'b0;
  end

  // Wait a number of system clock edges
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  // Send one async frame: start, 8 data LSB first, one stop
  task automatic send_async(input logic [7:0] b, input int t);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    cyc(1);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      cyc(t);
    end
  endtask : send_async

  // Capture one async frame; unknown result if none starts in lim cycles
  task automatic get_async(input int t, input int lim,
                           output logic [7:0] b);
    int n;
    n = 0;
    b = 'x;
    while (txd !== 1'b0 && n < lim) begin
      cyc(1);
      n++;
    end
    if (n < lim) begin
      // Half a bit lands every later sample in mid-bit
      cyc(t / 2);
      for (int i = 0; i < 8; i++) begin
        cyc(t);
        b[i] = txd;
      end
      cyc(t);
      // A missing stop level spoils the whole byte
      if (txd !== 1'b1) b = 'x;
    end
  endtask : get_async

  // Clock one synchronous frame both ways, remote as clock source
  task automatic sync_frame(input logic pol, input logic [7:0] b,
                            output logic [7:0] got);
    logic [13:0] s;
    logic [13:0] f;
    int k;
    f = {5'h1f, b, 1'b0};
    xck <= pol;
    cyc(8);
    for (int i = 0; i < 14; i++) begin
      // Change edge: rising for polarity 0, falling for 1
      xck <= !pol;
      rxd <= f[i];
      // Half period of 8 cycles keeps the pin at clock/16
      cyc(8);
      // Sample edge is the opposite one
      xck <= pol;
      s[i] = txd;
      cyc(8);
    end
    k = 0;
    while (k < 5 && s[k] !== 1'b0) k++;
    got = s[k + 1 +: 8];
    if (k == 5) got = 'x;
  endtask : sync_frame
endmodule : ucg_remote

// file: tb_top.sv
// Self-checking bench for the serial clock generation block
`timescale 1ns/100ps
module tb_top
  import ucg_pkg::*;
;
  logic clock = 1'b0; // System clock, 25 ns
  logic rst = 1'b1; // Held for 16 cycles
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic xck_out; // Device drive of the clock pin
  logic xck_oe_n; // Low while the device drives the pin
  logic xck_rem; // Remote drive of the clock pin
  logic pin_lvl; // Resolved clock pin level
  logic rxd;
  logic txd;
  logic [31:0] rdat; // Last read data
  logic rerr; // Last slave error
  logic [15:0] seed = 16'hab30; // LFSR state, starts at 43824
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;

  // The pin follows whoever has it enabled
  assign pin_lvl = (xck_oe_n === 1'b0) ? xck_out : xck_rem;

  ucg_top DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .transfer_clock_pin_in(pin_lvl), .transfer_clock_pin_out(xck_out),
    .transfer_clock_pin_oe_n(xck_oe_n), .receive_data_pin(rxd),
    .transmit_data_pin(txd));

  ucg_remote remote (.clock(clock), .txd(txd), .rxd(rxd), .xck(xck_rem));

  // Free-running clock
  always #12.5 clock = ~clock;

  // Hang guard, far above the few thousand cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      close_out();
    end
  end

  // Maximal-length 16-bit LFSR step
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction : rnd

  // Async bit time in system cycles
  function automatic int bit_time(input int d, input logic ds);
    return (d + 1) * (ds ? 8 : 16);
  endfunction : bit_time

  // Master clock period in system cycles
  function automatic int master_period(input int d);
    return 2 * (d + 1);
  endfunction : master_period

  // Compare a design value, unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // Compare a measured cycle count
  task automatic chk_time(input int got, input int exp, input string what);
    n_checks++;
    if (got != exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %0d want %0d", $time, what, got,
               exp);
    end
  endtask : chk_time

  // One APB transfer; waits on pready rather than assuming zero waits
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // No timeout here; only the hang guard ends a stuck wait
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write and read shorthands
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Poll until the transmit buffer has room again
  task automatic wait_room();
    int n;
    n = 0;
    rd(ADDR_STATUS);
    while (rdat[2] !== 1'b0 && n < 400) begin
      rd(ADDR_STATUS);
      n++;
    end
  endtask : wait_room

  // Cycles between two rises of the resolved clock pin
  task automatic rise_gap(output int n);
    logic p;
    int k;
    k = 0;
    n = 0;
    @(posedge clock);
    p = pin_lvl;
    while (k < 2 && n < 2000) begin
      @(posedge clock);
      if (k == 1) n++;
      if (pin_lvl === 1'b1 && p === 1'b0) k++;
      p = pin_lvl;
    end
  endtask : rise_gap

  // Counts, verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] g1;
    logic [7:0] g2;
    int t;
    int n;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    // Reset values, unmapped place, stale flags cleared
    rd(ADDR_CTRL);
    chk(rdat, 32'(CTRL_RESET), "ctrl reset");
    rd(ADDR_MASK);
    chk(rdat, 32'h0, "mask reset");
    rd(8'h1c);
    chk({rdat[30:0], rerr}, 32'h1, "unmapped read");
    rd(ADDR_IRQ);
    $display("test registers done");
    // Normal then double speed async, both directions
    for (int m = 0; m < 2; m++) begin
      d = rnd() & 8'h03;
      t = bit_time(d, m[0]);
      b1 = rnd();
      b2 = rnd();
      wr(ADDR_CTRL, 32'(m) << BIT_DS);
      wr(ADDR_BAUD_HI, 32'h0);
      wr(ADDR_BAUD_LO, 32'(d));
      chk(32'(xck_oe_n), 32'h1, "async pin released");
      fork
        begin
          remote.get_async(t, 3000, g1);
          remote.get_async(t, t + 4, g2);
        end
        begin
          wr(ADDR_DATA, 32'(b1));
          wait_room();
          wr(ADDR_DATA, 32'(b2));
        end
      join
      chk(32'(g1), 32'(b1), "async tx byte");
      chk(32'(g2), 32'(b2), "gapless tx byte");
      b1 = rnd();
      remote.send_async(b1, t);
      rd(ADDR_DATA);
      chk(rdat, 32'(b1), "async rx byte");
      $display("test async mode %0d done", m);
    end
    // Receive flag raises irq only when unmasked; read clears it
    chk(32'(irq), 32'h0, "masked irq");
    wr(ADDR_MASK, 32'h1 << IRQ_RXC);
    @(posedge clock);
    chk(32'(irq), 32'h1, "unmasked irq");
    rd(ADDR_IRQ);
    chk(32'(rdat[IRQ_RXC]), 32'h1, "rx flag");
    @(posedge clock);
    chk(32'(irq), 32'h0, "irq after clear");
    rd(ADDR_IRQ);
    chk(rdat, 32'h0, "flags after clear");
    $display("test interrupt done");
    // Master with double speed set, which must not change the rate
    d = rnd() & 8'h03;
    wr(ADDR_BAUD_LO, 32'(d));
    wr(ADDR_CTRL, 32'h7);
    @(posedge clock);
    chk(32'(xck_oe_n), 32'h0, "master drives pin");
    rise_gap(n);
    chk_time(n, master_period(d), "master period");
    $display("test master done");
    // Slave at both polarities, byte each way per frame
    for (int p = 0; p < 2; p++) begin
      b1 = rnd();
      b2 = rnd();
      wr(ADDR_CTRL, 32'h1 | (32'(p) << BIT_POL));
      @(posedge clock);
      chk(32'(xck_oe_n), 32'h1, "slave pin input");
      wr(ADDR_DATA, 32'(b1));
      remote.sync_frame(p[0], b2, g1);
      chk(32'(g1), 32'(b1), "slave tx byte");
      rd(ADDR_DATA);
      chk(rdat, 32'(b2), "slave rx byte");
      $display("test slave polarity %0d done", p);
    end
    // Even parity on; the remote sends a high parity slot, so 8'h5a
    // shows a parity error; three frames overrun the two-entry buffer
    wr(ADDR_CTRL, 32'h19);
    repeat (3) remote.sync_frame(1'b1, 8'h5a, g2);
    rd(ADDR_STATUS);
    chk(32'(rdat[7:3]), 32'h13, "overrun status");
    rd(ADDR_STATUS);
    chk(32'(rdat[3]), 32'h0, "overrun cleared");
    $display("test overrun done");
    close_out();
  end
endmodule : tb_top
